// >>> sihc_pkg.sv
// Constants and types for the sensor record command handler.
// Assumes byte-wide request and reply streams on the mclk domain.
package sihc_pkg;

   // Command codes: four ASCII letters, first letter in the low byte
   localparam logic [31:0] CMD_ENC_ID_SET = 32'h696e6573;
   localparam logic [31:0] CMD_ENC_ID_GET = 32'h696e6567;
   localparam logic [31:0] CMD_ENC_SET_SET = 32'h736e6573;
   localparam logic [31:0] CMD_ENC_SET_GET = 32'h736e6567;
   localparam logic [31:0] CMD_HALL_ID_SET = 32'h69736873;
   localparam logic [31:0] CMD_HALL_ID_GET = 32'h69736867;

   // Frame pieces in bytes
   localparam logic [7:0] CODE_BYTES = 8'h04;
   localparam logic [7:0] CRC_BYTES = 8'h02;
   localparam logic [7:0] MFR_LEN = 8'h10;
   localparam logic [7:0] PART_LEN = 8'h18;
   localparam logic [7:0] RSV_LEN = 8'h18;
   localparam logic [7:0] FLOAT_BYTES = 8'h04;
   localparam logic [7:0] WORD_BYTES = 8'h04;
   localparam logic [7:0] ID_LEN = MFR_LEN + PART_LEN + RSV_LEN;
   localparam logic [7:0] SET_LEN = 8'h04 * FLOAT_BYTES + WORD_BYTES
      + WORD_BYTES + RSV_LEN;
   localparam logic [7:0] NO_LEN = 8'h00;

   // Record placement in the nonvolatile store
   localparam logic [7:0] ENC_ID_BASE = 8'h00;
   localparam logic [7:0] ENC_SET_BASE = ENC_ID_BASE + ID_LEN;
   localparam logic [7:0] HALL_ID_BASE = ENC_SET_BASE + SET_LEN;
   localparam int NVM_BYTES = int'(HALL_ID_BASE) + int'(ID_LEN);
   localparam int STAGE_BYTES = int'(ID_LEN);

   // Flag word: follows four floats and the counts per turn word
   localparam logic [7:0] FLAG_OFS = 8'h04 * FLOAT_BYTES + WORD_BYTES;
   localparam logic [7:0] FLAG_ADDR0 = ENC_SET_BASE + FLAG_OFS;
   localparam logic [7:0] FLAG_ADDR1 = FLAG_ADDR0 + 8'h01;
   localparam int FLAG_BALANCED_BIT = 0;
   localparam int FLAG_TOTEM_BIT = 2;
   localparam int FLAG_INDEX_BIT = 4;
   localparam int FLAG_TURN_BIT = 6;
   localparam int FLAG_POL_BIT = 0;

   // Checksum: reflected 16-bit polynomial
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } sihc_byte_type;

   typedef struct packed {
      logic balanced_outputs;
      logic totem_outputs;
      logic has_index;
      logic has_turn_sensor;
      logic turn_sensor_polarity;
   } sihc_flags_type;

   typedef enum logic [2:0] {
      ST_CODE,
      ST_BODY,
      ST_CHECK,
      ST_COMMIT,
      ST_TX
   } sihc_state_type;

endpackage

// >>> sihc_crc16.sv
// Running 16-bit checksum over a byte stream, one byte per step.
// Assumes the caller clears it before the first byte of a payload.
`timescale 1ns/100ps
module sihc_crc16 (
   input wire logic mclk,
   input wire logic rst,
   input wire logic clear,
   input wire logic step,
   input wire logic [7:0] data,
   output logic [15:0] crc
);

   logic [15:0] crc_reg;
   logic [15:0] crc_next;

   function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                            input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ sihc_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   assign crc_next = clear ? sihc_pkg::CRC_INIT :
                     step ? crc_byte(crc_reg, data) : crc_reg;
   assign crc = crc_reg;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         crc_reg <= sihc_pkg::CRC_INIT;
      end else begin
         crc_reg <= crc_next;
      end
   end

endmodule // sihc_crc16

// >>> sihc_handler.sv
// Sensor record command handler: takes request frames byte by byte,
// stores or returns encoder and hall sensor records, sends replies.
// Assumes upstream framing delivers whole frames on the mclk domain.
`timescale 1ns/100ps

module sihc_handler (
   input wire logic mclk,
   input wire logic rst,
   input sihc_pkg::sihc_byte_type rx,
   output logic rx_ready,
   output sihc_pkg::sihc_byte_type tx,
   input wire logic tx_ready,
   output sihc_pkg::sihc_flags_type flags,
   output logic busy,
   output logic crc_error,
   output logic cmd_unknown,
   output logic write_done
);

   function automatic logic [7:0] cmd_len(input logic [31:0] c);
      unique case (c)
         sihc_pkg::CMD_ENC_ID_SET, sihc_pkg::CMD_ENC_ID_GET,
         sihc_pkg::CMD_HALL_ID_SET, sihc_pkg::CMD_HALL_ID_GET:
            return sihc_pkg::ID_LEN;
         sihc_pkg::CMD_ENC_SET_SET, sihc_pkg::CMD_ENC_SET_GET:
            return sihc_pkg::SET_LEN;
         default:
            return sihc_pkg::NO_LEN;
      endcase
   endfunction
   function automatic logic cmd_is_write(input logic [31:0] c);
      return c == sihc_pkg::CMD_ENC_ID_SET ||
             c == sihc_pkg::CMD_ENC_SET_SET ||
             c == sihc_pkg::CMD_HALL_ID_SET;
   endfunction
   function automatic logic [7:0] cmd_base(input logic [31:0] c);
      if (c == sihc_pkg::CMD_ENC_SET_SET || c == sihc_pkg::CMD_ENC_SET_GET)
         return sihc_pkg::ENC_SET_BASE;
      else if (c == sihc_pkg::CMD_HALL_ID_SET ||
               c == sihc_pkg::CMD_HALL_ID_GET)
         return sihc_pkg::HALL_ID_BASE;
      else
         return sihc_pkg::ENC_ID_BASE;
   endfunction

   sihc_pkg::sihc_state_type st_reg, st_next;
   logic [7:0] cnt_reg, cnt_next, idx_reg, len_reg, base_reg;
   logic [7:0] crc_lo_reg, tx_data_reg;
   logic [31:0] code_reg;
   logic rd_reg, tx_valid_reg, crc_err_reg, unk_reg, done_reg;
   logic [7:0] stage [0:sihc_pkg::STAGE_BYTES-1];
   logic [7:0] mem [0:sihc_pkg::NVM_BYTES-1];

   logic rx_fire, code_done, dec_write, dec_ok, body_done;
   logic check_done, crc_match, slot_free, tx_load, tx_end;
   logic tx_in_body, commit_we, commit_last;
   logic [31:0] code_full;
   logic [15:0] rx_crc, tx_crc;
   logic [7:0] dec_len, dec_base, body_end, tx_total, tx_addr, tx_sel;
   logic [7:0] commit_addr, stage_rd;
   logic [3:0] stage_flag4;

   assign rx_fire = rx.valid && rx_ready;
   assign rx_ready = st_reg == sihc_pkg::ST_CODE ||
                     st_reg == sihc_pkg::ST_BODY ||
                     st_reg == sihc_pkg::ST_CHECK;
   assign code_full = {rx.data, code_reg[31:8]};
   assign code_done = rx_fire && st_reg == sihc_pkg::ST_CODE &&
                      cnt_reg == sihc_pkg::CODE_BYTES - 8'h01;
   assign dec_len = cmd_len(code_full);
   assign dec_write = cmd_is_write(code_full);
   assign dec_base = cmd_base(code_full);
   assign dec_ok = dec_len != sihc_pkg::NO_LEN;
   assign body_done = rx_fire && st_reg == sihc_pkg::ST_BODY &&
                      cnt_reg == len_reg - 8'h01;
   assign check_done = rx_fire && st_reg == sihc_pkg::ST_CHECK &&
                       cnt_reg == sihc_pkg::CRC_BYTES - 8'h01;
   assign crc_match = {rx.data, crc_lo_reg} == rx_crc;
   assign slot_free = !tx_valid_reg || tx_ready;
   assign body_end = sihc_pkg::CODE_BYTES + len_reg;
   assign tx_total = rd_reg ? body_end + sihc_pkg::CRC_BYTES :
                     sihc_pkg::CODE_BYTES;
   assign tx_load = st_reg == sihc_pkg::ST_TX && slot_free &&
                    idx_reg < tx_total;
   assign tx_end = st_reg == sihc_pkg::ST_TX && slot_free &&
                   idx_reg == tx_total;
   assign tx_in_body = idx_reg >= sihc_pkg::CODE_BYTES &&
                       idx_reg < body_end;
   assign tx_addr = base_reg + idx_reg - sihc_pkg::CODE_BYTES;
   assign commit_we = st_reg == sihc_pkg::ST_COMMIT;
   assign commit_last = cnt_reg == len_reg - 8'h01;
   assign commit_addr = base_reg + cnt_reg;
   assign stage_rd = stage[cnt_reg[5:0]];
   assign stage_flag4 = {stage_rd[sihc_pkg::FLAG_TURN_BIT],
                         stage_rd[sihc_pkg::FLAG_INDEX_BIT],
                         stage_rd[sihc_pkg::FLAG_TOTEM_BIT],
                         stage_rd[sihc_pkg::FLAG_BALANCED_BIT]};

   // Reply byte: code echo, stored record, then checksum low first
   assign tx_sel = idx_reg < sihc_pkg::CODE_BYTES ?
                   code_reg[{idx_reg[1:0], 3'h0} +: 8] :
                   tx_in_body ? mem[tx_addr] :
                   idx_reg == body_end ? tx_crc[7:0] : tx_crc[15:8];

   assign cnt_next = (code_done || body_done || check_done ||
                      (commit_we && commit_last)) ? 8'h00 :
                     (rx_fire || commit_we) ? cnt_reg + 8'h01 : cnt_reg;

   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         sihc_pkg::ST_CODE: begin
            if (code_done && dec_ok) begin
               st_next = dec_write ? sihc_pkg::ST_BODY : sihc_pkg::ST_TX;
            end
         end
         sihc_pkg::ST_BODY: begin
            if (body_done) begin
               st_next = sihc_pkg::ST_CHECK;
            end
         end
         sihc_pkg::ST_CHECK: begin
            if (check_done) begin
               st_next = crc_match ? sihc_pkg::ST_COMMIT :
                         sihc_pkg::ST_CODE;
            end
         end
         sihc_pkg::ST_COMMIT: begin
            if (commit_last) begin
               st_next = sihc_pkg::ST_TX;
            end
         end
         sihc_pkg::ST_TX: begin
            if (tx_end) begin
               st_next = sihc_pkg::ST_CODE;
            end
         end
      endcase
   end

   sihc_crc16 u_rx_crc (
      .mclk(mclk),
      .rst(rst),
      .clear(code_done),
      .step(rx_fire && st_reg == sihc_pkg::ST_BODY),
      .data(rx.data),
      .crc(rx_crc)
   );
   sihc_crc16 u_tx_crc (
      .mclk(mclk),
      .rst(rst),
      .clear(st_reg != sihc_pkg::ST_TX),
      .step(tx_load && rd_reg && tx_in_body),
      .data(mem[tx_addr]),
      .crc(tx_crc)
   );

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_reg <= sihc_pkg::ST_CODE;
         cnt_reg <= 8'h00;
         code_reg <= 32'h00000000;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         if (rx_fire && st_reg == sihc_pkg::ST_CODE) begin
            code_reg <= code_full;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         len_reg <= 8'h00;
         base_reg <= 8'h00;
         rd_reg <= 1'b0;
         crc_lo_reg <= 8'h00;
      end else begin
         if (code_done) begin
            len_reg <= dec_len;
            base_reg <= dec_base;
            rd_reg <= !dec_write;
         end
         if (rx_fire && st_reg == sihc_pkg::ST_CHECK) begin
            crc_lo_reg <= rx.data;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rx_fire && st_reg == sihc_pkg::ST_BODY) begin
         stage[cnt_reg[5:0]] <= rx.data;
      end
   end

   // Nonvolatile store, written only from a checked staging copy
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < sihc_pkg::NVM_BYTES; i++) begin
            mem[i] <= 8'h00;
         end
      end else if (commit_we) begin
         mem[commit_addr] <= stage_rd;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         idx_reg <= 8'h00;
         tx_valid_reg <= 1'b0;
         tx_data_reg <= 8'h00;
      end else begin
         if (tx_load) begin
            idx_reg <= idx_reg + 8'h01;
            tx_valid_reg <= 1'b1;
            tx_data_reg <= tx_sel;
         end else if (tx_end) begin
            idx_reg <= 8'h00;
            tx_valid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         crc_err_reg <= 1'b0;
         unk_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         crc_err_reg <= check_done && !crc_match;
         unk_reg <= code_done && !dec_ok;
         done_reg <= commit_we && commit_last;
      end
   end

   assign tx = {tx_valid_reg, tx_data_reg};
   assign busy = st_reg != sihc_pkg::ST_CODE || cnt_reg != 8'h00;
   assign crc_error = crc_err_reg;
   assign cmd_unknown = unk_reg;
   assign write_done = done_reg;
   assign flags.balanced_outputs =
      mem[sihc_pkg::FLAG_ADDR0][sihc_pkg::FLAG_BALANCED_BIT];
   assign flags.totem_outputs =
      mem[sihc_pkg::FLAG_ADDR0][sihc_pkg::FLAG_TOTEM_BIT];
   assign flags.has_index =
      mem[sihc_pkg::FLAG_ADDR0][sihc_pkg::FLAG_INDEX_BIT];
   assign flags.has_turn_sensor =
      mem[sihc_pkg::FLAG_ADDR0][sihc_pkg::FLAG_TURN_BIT];
   assign flags.turn_sensor_polarity =
      mem[sihc_pkg::FLAG_ADDR1][sihc_pkg::FLAG_POL_BIT];

   sequence s_code_in(logic [31:0] c);
      code_done && code_full == c;
   endsequence
   sequence s_read_start(logic [7:0] n);
      st_reg == sihc_pkg::ST_TX && rd_reg && tx_total == n;
   endsequence
   property p_enc_id_read;
      @(posedge mclk) disable iff (rst)
      s_code_in(sihc_pkg::CMD_ENC_ID_GET) |=> s_read_start(8'h46);
   endproperty
   a_enc_id_read: assert property (p_enc_id_read)
      else $error("Identity read answer is not 70 bytes");
   property p_set_read;
      @(posedge mclk) disable iff (rst)
      s_code_in(sihc_pkg::CMD_ENC_SET_GET) |=> s_read_start(8'h36);
   endproperty
   a_set_read: assert property (p_set_read)
      else $error("Settings read answer is not 54 bytes");
   property p_hall_read;
      @(posedge mclk) disable iff (rst)
      s_code_in(sihc_pkg::CMD_HALL_ID_GET) |=> s_read_start(8'h46)
         ##0 base_reg == 8'h70;
   endproperty
   a_hall_read: assert property (p_hall_read)
      else $error("Hall identity read misdirected");
   property p_write_body;
      @(posedge mclk) disable iff (rst)
      s_code_in(sihc_pkg::CMD_ENC_SET_SET) |=>
         st_reg == sihc_pkg::ST_BODY && len_reg == 8'h30;
   endproperty
   a_write_body: assert property (p_write_body)
      else $error("Settings write body length wrong");
   property p_bad_crc;
      @(posedge mclk) disable iff (rst)
      check_done && !crc_match |=>
         st_reg == sihc_pkg::ST_CODE && crc_error ##1 !tx.valid;
   endproperty
   a_bad_crc: assert property (p_bad_crc)
      else $error("Write with bad checksum went on");
   property p_ack;
      @(posedge mclk) disable iff (rst)
      commit_we && commit_last |=> st_reg == sihc_pkg::ST_TX &&
         tx_total == 8'h04 ##1 tx.valid && tx.data == code_reg[7:0];
   endproperty
   a_ack: assert property (p_ack)
      else $error("Write acknowledge is not a code echo");
   property p_store;
      @(posedge mclk) disable iff (rst)
      commit_we |=> mem[$past(commit_addr)] == $past(stage_rd);
   endproperty
   a_store: assert property (p_store)
      else $error("Record byte not stored");
   property p_flags;
      @(posedge mclk) disable iff (rst)
      commit_we && commit_addr == sihc_pkg::FLAG_ADDR0 |=>
         {flags.has_turn_sensor, flags.has_index, flags.totem_outputs,
          flags.balanced_outputs} == $past(stage_flag4);
   endproperty
   a_flags: assert property (p_flags)
      else $error("Flag outputs do not follow stored flag word");
   property p_tx_hold;
      @(posedge mclk) disable iff (rst)
      tx.valid && !tx_ready |=> tx.valid && $stable(tx.data);
   endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("Reply byte changed while stalled");

endmodule // sihc_handler

// >>> sihc_host.sv
// Host model: offers request bytes and drains reply bytes.
// Assumes rising-edge handshakes; drives its lines on falling edges.
`timescale 1ns/100ps
module sihc_host (
   input wire logic mclk,
   input wire logic rst,
   input wire logic rx_ready,
   input sihc_pkg::sihc_byte_type tx,
   output sihc_pkg::sihc_byte_type rx,
   output logic tx_ready
);
   logic [7:0] rq[$];
   logic [7:0] last_byte;
   logic slow;
   int tick;
   initial begin
      rx = '0;
      tx_ready = 1'b0;
      slow = 1'b0;
      tick = 0;
      last_byte = 8'h00;
   end
   // Reply side: ready every cycle, or every third cycle when slow
   always @(negedge mclk) begin
      tick <= tick + 1;
      if (rst) begin
         tx_ready <= 1'b0;
      end else begin
         tx_ready <= !slow || (tick % 3 == 0);
      end
   end
   // A reply byte is taken at the edge that sees valid and ready
   always @(posedge mclk) begin
      if (rst === 1'b0 && tx.valid === 1'b1 && tx_ready === 1'b1) begin
         rq.push_back(tx.data);
      end
   end
   // Request side: hold the byte until an edge with rx_ready high
   task automatic send_byte(input logic [7:0] b);
      int n;
      @(negedge mclk);
      rx <= '{valid: 1'b1, data: b};
      last_byte = b;
      n = 0;
      #1;
      while (rx_ready !== 1'b1 && n < 500) begin
         @(negedge mclk);
         #1;
         n++;
      end
      @(posedge mclk);
   endtask
   // Released line carries the inverse of the last byte
   task automatic release_rx();
      @(negedge mclk);
      rx <= '{valid: 1'b0, data: ~last_byte};
   endtask
endmodule // sihc_host

// >>> tb_top.sv
// Testbench for the sensor record command handler.
// Assumes the host model sits on the request and reply streams.
`timescale 1ns/100ps
module tb_top;
   typedef logic [7:0] sihc_bq_type[$];
   logic mclk;
   logic rst;
   sihc_pkg::sihc_byte_type rx;
   sihc_pkg::sihc_byte_type tx;
   sihc_pkg::sihc_flags_type flags;
   logic rx_ready, tx_ready, busy, crc_error, cmd_unknown, write_done;
   int err_total, checked, cyc, done_cnt, crc_cnt, unk_cnt;
   sihc_bq_type enc_id, enc_set, hall_id, none;
   logic [15:0] fw[3];

   sihc_handler sihc_handler_i (.mclk(mclk), .rst(rst), .rx(rx),
      .rx_ready(rx_ready), .tx(tx), .tx_ready(tx_ready), .flags(flags),
      .busy(busy), .crc_error(crc_error), .cmd_unknown(cmd_unknown),
      .write_done(write_done));
   sihc_host sihc_host_i (.mclk(mclk), .rst(rst), .rx_ready(rx_ready),
      .tx(tx), .rx(rx), .tx_ready(tx_ready));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Status pulses counted where they are settled
   always @(negedge mclk) begin
      if (rst === 1'b0) begin
         done_cnt += (write_done === 1'b1);
         crc_cnt += (crc_error === 1'b1);
         unk_cnt += (cmd_unknown === 1'b1);
      end
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         wrap_up();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("Checks %0d, errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   function automatic logic [15:0] crc16(input sihc_bq_type d);
      logic [15:0] c;
      c = 16'hffff;
      foreach (d[i]) begin
         c = c ^ {8'h00, d[i]};
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
         end
      end
      return c;
   endfunction
   function automatic sihc_bq_type fill(input int n, input logic [7:0] s);
      sihc_bq_type q;
      for (int i = 0; i < n; i++) begin
         q.push_back(s + 8'(i * 7));
      end
      return q;
   endfunction
   // Code low byte first, body, then checksum low byte first
   task automatic send_frame(input logic [31:0] code, input sihc_bq_type body,
      input logic has_crc, input logic bad);
      logic [15:0] c;
      c = crc16(body);
      for (int i = 0; i < 4; i++) sihc_host_i.send_byte(code[8*i+:8]);
      foreach (body[i]) sihc_host_i.send_byte(body[i]);
      if (has_crc) begin
         sihc_host_i.send_byte(c[7:0] ^ {7'h00, bad});
         sihc_host_i.send_byte(c[15:8]);
      end
      sihc_host_i.release_rx();
   endtask
   task automatic expect_reply(input sihc_bq_type exp);
      int n;
      n = 0;
      while (sihc_host_i.rq.size() < exp.size() && n < 3000) begin
         @(negedge mclk);
         n++;
      end
      repeat (exp.size() == 0 ? 150 : 20) @(negedge mclk);
      check(16'(sihc_host_i.rq.size()), 16'(exp.size()));
      foreach (exp[i]) begin
         if (i < sihc_host_i.rq.size()) begin
            check({8'h00, sihc_host_i.rq[i]}, {8'h00, exp[i]});
         end
      end
      sihc_host_i.rq.delete();
   endtask
   task automatic wr(input logic [31:0] code, input sihc_bq_type body,
      input logic bad);
      sihc_bq_type exp;
      int d0, c0;
      d0 = done_cnt;
      c0 = crc_cnt;
      send_frame(code, body, 1'b1, bad);
      for (int i = 0; i < 4 && !bad; i++) exp.push_back(code[8*i+:8]);
      expect_reply(exp);
      check(16'(done_cnt - d0), {15'h0000, !bad});
      check(16'(crc_cnt - c0), {15'h0000, bad});
   endtask
   task automatic rd(input logic [31:0] code, input sihc_bq_type rec);
      sihc_bq_type exp;
      logic [15:0] c;
      c = crc16(rec);
      for (int i = 0; i < 4; i++) exp.push_back(code[8*i+:8]);
      exp = {exp, rec, c[7:0], c[15:8]};
      send_frame(code, none, 1'b0, 1'b0);
      check({14'h0000, rx_ready, busy}, 16'h0001);
      expect_reply(exp);
   endtask

   initial begin
      rst = 1'b1;
      err_total = 0;
      checked = 0;
      cyc = 0;
      done_cnt = 0;
      crc_cnt = 0;
      unk_cnt = 0;
      fw = '{16'h0155, 16'h0014, 16'h0141};
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      check({12'h000, rx_ready, tx.valid, busy, 1'b0}, 16'h0008);
      check({11'h000, flags}, 16'h0000);
      enc_id = fill(64, 8'h00);
      for (int i = 0; i < 64; i++) enc_id[i] = 8'h00;
      enc_set = enc_id[0:47];
      hall_id = enc_id;
      rd(32'h696e6567, enc_id);
      rd(32'h736e6567, enc_set);
      enc_id = fill(64, 8'h41);
      wr(32'h696e6573, enc_id, 1'b0);
      rd(32'h696e6567, enc_id);
      foreach (fw[j]) begin
         enc_set = fill(48, 8'h10 + 8'(j));
         enc_set[20] = fw[j][7:0];
         enc_set[21] = fw[j][15:8];
         wr(32'h736e6573, enc_set, 1'b0);
         check({11'h000, flags}, {11'h000, fw[j][0], fw[j][2], fw[j][4],
            fw[j][6], fw[j][8]});
         rd(32'h736e6567, enc_set);
      end
      sihc_host_i.slow = 1'b1;
      hall_id = fill(64, 8'hc3);
      wr(32'h69736873, hall_id, 1'b0);
      rd(32'h69736867, hall_id);
      sihc_host_i.slow = 1'b0;
      wr(32'h696e6573, fill(64, 8'h90), 1'b1);
      rd(32'h696e6567, enc_id);
      send_frame(32'h11223344, none, 1'b0, 1'b0);
      expect_reply(none);
      check(16'(unk_cnt), 16'h0001);
      rd(32'h69736867, hall_id);
      wrap_up();
   end
endmodule // tb_top
